//--- hdl/param_table_flash.sv
`timescale 1ns/1ns
module param_table_flash (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // Serial link pins
    input wire logic link_sclk_i,
    input wire logic link_cs_n_i,
    input wire logic [3:0] io_i,
    output logic [3:0] io_o,
    output logic [3:0] io_oe_n_o,
    // Configuration from local logic
    input wire logic [1:0] line_mode_i,
    // Status
    output logic write_enable_latch_flag_o,
    output logic deep_power_down_o,
    output logic ready_o
);

    logic sclk_s;
    logic cs_n_s;
    logic [3:0] io_s;
    logic sclk_prev_q;
    logic rise;
    logic fall;

    logic [15:0] delay_cnt_q;
    logic [15:0] delay_cnt_d;
    logic ready_q;
    logic ready_d;

    param_table_pkg::state_type state_q;
    param_table_pkg::state_type state_d;
    logic [1:0] frame_mode_q;
    logic [1:0] frame_mode_d;
    logic [23:0] shift_q;
    logic [23:0] shift_d;
    logic [4:0] bit_cnt_q;
    logic [4:0] bit_cnt_d;
    logic [23:0] addr_q;
    logic [23:0] addr_d;
    logic [7:0] out_sr_q;
    logic [7:0] out_sr_d;
    logic [3:0] out_left_q;
    logic [3:0] out_left_d;
    logic [3:0] io_out_q;
    logic [3:0] io_out_d;
    logic [3:0] io_oe_n_q;
    logic [3:0] io_oe_n_d;
    logic wel_q;
    logic wel_d;
    logic dpd_q;
    logic dpd_d;
    logic load_fire;
    logic [7:0] loaded_q;
    logic [7:0] load_byte;

    pin_sync #(
        .WIDTH(6),
        .RESET_VALUE(param_table_pkg::PIN_SYNC_RESET)
    ) u_pin_sync (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .pins_i({link_sclk_i, link_cs_n_i, io_i}),
        .pins_o({sclk_s, cs_n_s, io_s})
    );

    assign rise = sclk_s & ~sclk_prev_q;
    assign fall = ~sclk_s & sclk_prev_q;

    function automatic logic [4:0] lines_of(input logic [1:0] mode);
        case (mode)
            param_table_pkg::LINES_DUAL: lines_of = 5'h02;
            param_table_pkg::LINES_QUAD: lines_of = 5'h04;
            default: lines_of = 5'h01;
        endcase
    endfunction

    function automatic logic [23:0] shift_in(input logic [23:0] sr, input logic [1:0] mode,
                                             input logic [3:0] pins);
        case (mode)
            param_table_pkg::LINES_DUAL: shift_in = {sr[21:0], pins[1:0]};
            param_table_pkg::LINES_QUAD: shift_in = {sr[19:0], pins[3:0]};
            default: shift_in = {sr[22:0], pins[0]};
        endcase
    endfunction

    // Top bits of the byte onto the data lines, most significant first
    function automatic logic [3:0] drive_bits(input logic [7:0] b, input logic [1:0] mode);
        case (mode)
            param_table_pkg::LINES_DUAL: drive_bits = {2'b00, b[7:6]};
            param_table_pkg::LINES_QUAD: drive_bits = b[7:4];
            default: drive_bits = {2'b00, b[7], 1'b0};
        endcase
    endfunction

    function automatic logic [3:0] drive_mask(input logic [1:0] mode);
        case (mode)
            param_table_pkg::LINES_DUAL: drive_mask = 4'h3;
            param_table_pkg::LINES_QUAD: drive_mask = 4'hF;
            default: drive_mask = 4'h2;
        endcase
    endfunction

    // Table lookup, byte lane picked by the low address bits
    function automatic logic [7:0] table_byte(input logic [23:0] a);
        logic [31:0] word;
        word = param_table_pkg::RESERVED_CAPS_WORD_VALUE;
        case (a[3:2])
            2'h0: word = param_table_pkg::SUPPLY_VOLTAGE_RANGE_WORD_VALUE;
            2'h1: word = param_table_pkg::RESET_SUSPEND_WRAP_CAPS_WORD_VALUE;
            2'h2: word = param_table_pkg::BLOCK_LOCK_OTP_CAPS_WORD_VALUE;
            default: word = param_table_pkg::RESERVED_CAPS_WORD_VALUE;
        endcase
        if (a[23:4] != param_table_pkg::TABLE_WINDOW) begin
            table_byte = param_table_pkg::BLANK_BYTE;
        end else begin
            table_byte = word[8*a[1:0] +: 8];
        end
    endfunction

    // Power-up select delay
    always_comb begin
        delay_cnt_d = delay_cnt_q;
        ready_d = ready_q;
        if (!ready_q) begin
            delay_cnt_d = delay_cnt_q + 16'h0001;
            if (delay_cnt_q == 16'(param_table_pkg::POWER_UP_SELECT_DELAY_CYCLES - 1)) begin
                ready_d = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            delay_cnt_q <= 16'h0000;
            ready_q <= 1'b0;
        end else begin
            delay_cnt_q <= delay_cnt_d;
            ready_q <= ready_d;
        end
    end

    assign load_fire = !cs_n_s && fall && state_q == param_table_pkg::ST_DATA &&
                       out_left_q == 4'h0;
    assign load_byte = table_byte(addr_q);

    // Frame sequencing
    always_comb begin
        logic [4:0] lines;
        logic [4:0] next_cnt;
        lines = lines_of(frame_mode_q);
        next_cnt = bit_cnt_q + lines;
        state_d = state_q;
        frame_mode_d = frame_mode_q;
        shift_d = shift_q;
        bit_cnt_d = bit_cnt_q;
        addr_d = addr_q;
        out_sr_d = out_sr_q;
        out_left_d = out_left_q;
        io_out_d = io_out_q;
        io_oe_n_d = io_oe_n_q;
        wel_d = wel_q;
        dpd_d = dpd_q;
        if (cs_n_s) begin
            state_d = param_table_pkg::ST_OPCODE;
            frame_mode_d = line_mode_i;
            bit_cnt_d = 5'h00;
            out_left_d = 4'h0;
            io_oe_n_d = param_table_pkg::IO_OE_N_RESET;
        end else begin
            case (state_q)
                param_table_pkg::ST_OPCODE: begin
                    if (rise) begin
                        shift_d = shift_in(shift_q, frame_mode_q, io_s);
                        bit_cnt_d = next_cnt;
                        if (next_cnt == param_table_pkg::OPCODE_BITS) begin
                            bit_cnt_d = 5'h00;
                            state_d = param_table_pkg::ST_IGNORE;
                            if (!ready_q) begin
                                state_d = param_table_pkg::ST_IGNORE;
                            end else if (frame_mode_q == param_table_pkg::LINES_INVALID) begin
                                state_d = param_table_pkg::ST_IGNORE;
                            end else if (dpd_q) begin
                                if (shift_d[7:0] == param_table_pkg::OP_RELEASE_POWER_DOWN) begin
                                    dpd_d = 1'b0;
                                end
                            end else begin
                                case (shift_d[7:0])
                                    param_table_pkg::OP_READ_PARAM_TABLE: begin
                                        state_d = param_table_pkg::ST_ADDR;
                                    end
                                    param_table_pkg::OP_WRITE_ENABLE: begin
                                        wel_d = 1'b1;
                                    end
                                    param_table_pkg::OP_WRITE_DISABLE: begin
                                        wel_d = 1'b0;
                                    end
                                    param_table_pkg::OP_DEEP_POWER_DOWN: begin
                                        dpd_d = 1'b1;
                                    end
                                    default: begin
                                        state_d = param_table_pkg::ST_IGNORE;
                                    end
                                endcase
                            end
                        end
                    end
                end
                param_table_pkg::ST_ADDR: begin
                    if (rise) begin
                        shift_d = shift_in(shift_q, frame_mode_q, io_s);
                        bit_cnt_d = next_cnt;
                        if (next_cnt == param_table_pkg::ADDR_BITS) begin
                            addr_d = shift_d;
                            bit_cnt_d = 5'h00;
                            state_d = param_table_pkg::ST_DUMMY;
                        end
                    end
                end
                param_table_pkg::ST_DUMMY: begin
                    if (rise) begin
                        bit_cnt_d = bit_cnt_q + 5'h01;
                        if (bit_cnt_q == param_table_pkg::DUMMY_CLOCKS - 5'h01) begin
                            state_d = param_table_pkg::ST_DATA;
                        end
                    end
                end
                param_table_pkg::ST_DATA: begin
                    if (fall) begin
                        io_oe_n_d = ~drive_mask(frame_mode_q);
                        if (out_left_q == 4'h0) begin
                            io_out_d = drive_bits(load_byte, frame_mode_q);
                            out_sr_d = load_byte << lines;
                            out_left_d = param_table_pkg::BYTE_BITS - lines[3:0];
                            addr_d = addr_q + 24'h000001;
                        end else begin
                            io_out_d = drive_bits(out_sr_q, frame_mode_q);
                            out_sr_d = out_sr_q << lines;
                            out_left_d = out_left_q - lines[3:0];
                        end
                    end
                end
                param_table_pkg::ST_IGNORE: begin
                    state_d = param_table_pkg::ST_IGNORE;
                end
                default: begin
                    state_d = param_table_pkg::ST_IGNORE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            sclk_prev_q <= 1'b0;
            state_q <= param_table_pkg::ST_OPCODE;
            frame_mode_q <= param_table_pkg::LINES_SINGLE;
            shift_q <= 24'h000000;
            bit_cnt_q <= 5'h00;
            addr_q <= 24'h000000;
            out_sr_q <= 8'h00;
            out_left_q <= 4'h0;
            io_out_q <= 4'h0;
            io_oe_n_q <= param_table_pkg::IO_OE_N_RESET;
            wel_q <= param_table_pkg::WRITE_ENABLE_LATCH_RESET;
            dpd_q <= param_table_pkg::DEEP_POWER_DOWN_RESET;
            loaded_q <= 8'h00;
        end else begin
            sclk_prev_q <= sclk_s;
            state_q <= state_d;
            frame_mode_q <= frame_mode_d;
            shift_q <= shift_d;
            bit_cnt_q <= bit_cnt_d;
            addr_q <= addr_d;
            out_sr_q <= out_sr_d;
            out_left_q <= out_left_d;
            io_out_q <= io_out_d;
            io_oe_n_q <= io_oe_n_d;
            wel_q <= wel_d;
            dpd_q <= dpd_d;
            loaded_q <= load_fire ? load_byte : loaded_q;
        end
    end

    assign io_o = io_out_q;
    assign io_oe_n_o = io_oe_n_q;
    assign write_enable_latch_flag_o = wel_q;
    assign deep_power_down_o = dpd_q;
    assign ready_o = ready_q;

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (reset_i);

    sequence entering_data;
        state_q != param_table_pkg::ST_DATA ##1 state_q == param_table_pkg::ST_DATA;
    endsequence

    sequence loading_at(logic [23:0] a);
        load_fire && addr_q == a;
    endsequence

    supply_max_a: assert property (loading_at(24'h000061) |=> loaded_q == 8'h36)
        else $error("maximum supply byte wrong");
    supply_min_a: assert property (loading_at(24'h000063) |=> loaded_q == 8'h27)
        else $error("minimum supply byte wrong");
    reset_caps_a: assert property (loading_at(24'h000064) |=> loaded_q[3:0] == 4'h4)
        else $error("reset capability bits wrong");
    sw_reset_op_a: assert property (loading_at(24'h000064) |=> loaded_q[7:4] == 4'hF)
        else $error("software reset opcode bits wrong");
    suspend_wrap_a: assert property (loading_at(24'h000065) |=> loaded_q == 8'h4F)
        else $error("suspend and wrap bits wrong");
    block_lock_a: assert property (loading_at(24'h000068) |=> loaded_q == 8'hD9)
        else $error("block lock byte wrong");
    lock_default_a: assert property (loading_at(24'h000069) |=> loaded_q == 8'hF8)
        else $error("lock default byte wrong");
    blank_fields_a: assert property ((load_fire && addr_q[23:2] == 22'h00001B)
        |=> loaded_q == param_table_pkg::BLANK_BYTE)
        else $error("unused field not all ones");
    line_mode_a: assert property ((frame_mode_q == param_table_pkg::LINES_INVALID &&
        state_q == param_table_pkg::ST_OPCODE) |=> state_q != param_table_pkg::ST_ADDR)
        else $error("table read accepted in bad line mode");
    dummy_wait_a: assert property (entering_data |->
        $past(state_q) == param_table_pkg::ST_DUMMY &&
        $past(bit_cnt_q) == param_table_pkg::DUMMY_CLOCKS - 5'h01)
        else $error("data began before all dummy clocks");
    standby_start_a: assert property ($past(reset_i) |-> !dpd_q ##1 !dpd_q)
        else $error("not in standby after power-up");
    latch_clear_a: assert property ($past(reset_i) |-> !wel_q)
        else $error("write enable latch set after power-up");
    select_delay_a: assert property (!ready_q |=> state_q == param_table_pkg::ST_OPCODE ||
        state_q == param_table_pkg::ST_IGNORE)
        else $error("command accepted before select delay");
    byte_order_a: assert property ((load_fire && addr_q == 24'h000064 &&
        frame_mode_q == param_table_pkg::LINES_SINGLE) |=> io_out_q[1] && io_oe_n_q == 4'hD)
        else $error("first bit of byte not driven first");

endmodule

//--- hdl/param_table_pkg.sv
package param_table_pkg;

    // Clock and power-up timing
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned POWER_UP_SELECT_DELAY_NS = 800;
    localparam int unsigned POWER_UP_SELECT_DELAY_CYCLES =
        (POWER_UP_SELECT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Command opcodes
    localparam logic [7:0] OP_READ_PARAM_TABLE = 8'h5A;
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_DEEP_POWER_DOWN = 8'hB9;
    localparam logic [7:0] OP_RELEASE_POWER_DOWN = 8'hAB;

    // Frame shape in bits and clocks
    localparam logic [4:0] OPCODE_BITS = 5'h08;
    localparam logic [4:0] ADDR_BITS = 5'h18;
    localparam logic [4:0] DUMMY_CLOCKS = 5'h08;
    localparam logic [3:0] BYTE_BITS = 4'h8;

    // Table placement: byte address bits 23:4 select the 16-byte window
    localparam logic [19:0] TABLE_WINDOW = 20'h00006;
    localparam logic [23:0] SUPPLY_VOLTAGE_RANGE_WORD_OFFSET = 24'h000060;
    localparam logic [23:0] RESET_SUSPEND_WRAP_CAPS_WORD_OFFSET = 24'h000064;
    localparam logic [23:0] BLOCK_LOCK_OTP_CAPS_WORD_OFFSET = 24'h000068;
    localparam logic [23:0] RESERVED_CAPS_WORD_OFFSET = 24'h00006C;

    // Table contents
    localparam logic [31:0] SUPPLY_VOLTAGE_RANGE_WORD_VALUE = 32'h27003600;
    localparam logic [31:0] RESET_SUSPEND_WRAP_CAPS_WORD_VALUE = 32'hFFFF4FF4;
    localparam logic [31:0] BLOCK_LOCK_OTP_CAPS_WORD_VALUE = 32'hFFFFF8D9;
    localparam logic [31:0] RESERVED_CAPS_WORD_VALUE = 32'hFFFFFFFF;
    localparam logic [7:0] BLANK_BYTE = 8'hFF;

    // Values after reset
    localparam logic WRITE_ENABLE_LATCH_RESET = 1'b0;
    localparam logic DEEP_POWER_DOWN_RESET = 1'b0;
    localparam logic [5:0] PIN_SYNC_RESET = 6'h10;
    localparam logic [3:0] IO_OE_N_RESET = 4'hF;

    typedef enum logic [1:0] {
        LINES_SINGLE = 2'b00,
        LINES_DUAL = 2'b01,
        LINES_QUAD = 2'b10,
        LINES_INVALID = 2'b11
    } line_mode_type;

    typedef enum logic [2:0] {
        ST_OPCODE = 3'b000,
        ST_ADDR = 3'b001,
        ST_DUMMY = 3'b010,
        ST_DATA = 3'b011,
        ST_IGNORE = 3'b100
    } state_type;

endpackage

//--- hdl/pin_sync.sv
`timescale 1ns/1ns
module pin_sync #(
    parameter int WIDTH = 6,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // Pins in, synchronised out
    input wire logic [WIDTH-1:0] pins_i,
    output logic [WIDTH-1:0] pins_o
);

    logic [WIDTH-1:0] first_q;
    logic [WIDTH-1:0] second_q;

    // First stage feeds only the second stage
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            first_q <= RESET_VALUE;
            second_q <= RESET_VALUE;
        end else begin
            first_q <= pins_i;
            second_q <= first_q;
        end
    end

    assign pins_o = second_q;

endmodule

//--- bench/flash_host_model.sv
`timescale 1ns/1ns
module flash_host_model (
    // Clock
    input wire logic sys_clk_i,
    // Link pins towards the device
    output logic link_sclk_o,
    output logic link_cs_n_o,
    output logic [3:0] host_io_o,
    // Resolved pins and device enables
    input wire logic [3:0] pins_i,
    input wire logic [3:0] dev_oe_n_i
);
    logic [7:0] rx_q[$];
    logic watch;
    int bad_cnt;

    // Deselected and clock low until the bench starts a frame
    initial begin
        link_sclk_o = 1'b0;
        link_cs_n_o = 1'b1;
        host_io_o = 4'h0;
        watch = 1'b0;
        bad_cnt = 0;
    end

    // Counts any device drive where the device must stay silent
    always @(posedge sys_clk_i) begin
        if (watch && dev_oe_n_i !== 4'hF) begin
            bad_cnt++;
        end
    end

    task automatic half();
        repeat (8) @(posedge sys_clk_i);
    endtask

    // One serial clock; a released bus shows a toggling pattern
    task automatic pulse(input logic [3:0] bits, input bit drive, output logic [3:0] seen);
        host_io_o <= drive ? bits : ~host_io_o;
        half();
        seen = pins_i;
        link_sclk_o <= 1'b1;
        half();
        link_sclk_o <= 1'b0;
    endtask

    // Opcode, optional address, dummies and data, all on the same lanes
    task automatic frame(input logic [7:0] op, input int lanes, input bit rd,
                         input logic [23:0] addr, input int nbytes, input bit quiet);
        logic [3:0] seen;
        logic [31:0] sh;
        logic [7:0] b;
        rx_q.delete();
        bad_cnt = 0;
        watch = 1'b1;
        b = 8'h00;
        sh = {op, addr};
        link_cs_n_o <= 1'b0;
        half();
        for (int i = 0; i < (rd ? 32 : 8) / lanes; i++) begin
            pulse(sh[31:28] >> (4 - lanes), 1'b1, seen);
            sh = sh << lanes;
        end
        if (rd) begin
            // No mode bits are sent for this read
            repeat (8) pulse(4'h0, 1'b0, seen);
        end
        if (!quiet) begin
            watch = 1'b0;
        end
        for (int n = 0; n < nbytes; n++) begin
            for (int i = 0; i < 8 / lanes; i++) begin
                pulse(4'h0, 1'b0, seen);
                if (lanes == 1) begin
                    seen = {3'b000, seen[1]};
                end
                b = (b << lanes) | 8'(seen & 4'((1 << lanes) - 1));
            end
            rx_q.push_back(b);
        end
        half();
        link_cs_n_o <= 1'b1;
        half();
        watch = 1'b0;
    endtask
endmodule

//--- bench/param_table_flash_tb.sv
`timescale 1ns/1ns
module param_table_flash_tb;
    logic sys_clk_i;
    logic reset_i;
    logic link_sclk;
    logic link_cs_n;
    logic [3:0] host_io;
    logic [3:0] pins;
    logic [3:0] dev_io;
    logic [3:0] dev_oe_n;
    logic [1:0] line_mode;
    logic write_enable_latch_flag;
    logic dpd;
    logic ready;
    int error_cnt;
    int checks;
    int n;
    logic [31:0] exp_w[4] = '{32'h27003600, 32'hFFFF4FF4, 32'hFFFFF8D9, 32'hFFFFFFFF};

    assign pins = (dev_oe_n & host_io) | (~dev_oe_n & dev_io);

    param_table_flash u_param_table_flash (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .link_sclk_i(link_sclk),
        .link_cs_n_i(link_cs_n),
        .io_i(pins),
        .io_o(dev_io),
        .io_oe_n_o(dev_oe_n),
        .line_mode_i(line_mode),
        .write_enable_latch_flag_o(write_enable_latch_flag),
        .deep_power_down_o(dpd),
        .ready_o(ready)
    );

    flash_host_model u_flash_host_model (
        .sys_clk_i(sys_clk_i),
        .link_sclk_o(link_sclk),
        .link_cs_n_o(link_cs_n),
        .host_io_o(host_io),
        .pins_i(pins),
        .dev_oe_n_i(dev_oe_n)
    );

    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("Checks %0d, errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic do_reset();
        reset_i <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
        reset_i <= 1'b0;
    endtask

    task automatic wait_ready(output int cnt);
        cnt = 0;
        while (ready !== 1'b1) begin
            @(posedge sys_clk_i);
            cnt++;
            if (cnt > 1000) begin
                error_cnt++;
                final_report();
            end
        end
    endtask

    // One frame with the given line-mode code; silence is checked outside data
    task automatic cmd(input logic [1:0] code, input int lanes, input logic [7:0] op,
                       input bit rd, input logic [23:0] addr, input int nb, input bit quiet);
        line_mode <= code;
        @(posedge sys_clk_i);
        u_flash_host_model.frame(op, lanes, rd, addr, nb, quiet);
        check(u_flash_host_model.bad_cnt, 0);
        check(dev_oe_n, 4'hF);
    endtask

    function automatic logic [31:0] word(input int k);
        return {u_flash_host_model.rx_q[4 * k + 3], u_flash_host_model.rx_q[4 * k + 2],
                u_flash_host_model.rx_q[4 * k + 1], u_flash_host_model.rx_q[4 * k]};
    endfunction

    initial begin
        reset_i = 1'b1;
        line_mode = 2'b10;
        error_cnt = 0;
        checks = 0;
        repeat (4) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        @(posedge sys_clk_i);
        #1;
        check(dev_oe_n, 4'hF);
        check(write_enable_latch_flag, 1'b0);
        check(dpd, 1'b0);
        check(ready, 1'b0);
        wait_ready(n);
        check(32'(n > 76 && n < 84), 1);
        // Write enable sent before the select delay must be ignored
        do_reset();
        cmd(2'b10, 4, param_table_pkg::OP_WRITE_ENABLE, 1'b0, 24'h0, 0, 1'b1);
        wait_ready(n);
        check(write_enable_latch_flag, 1'b0);
        cmd(2'b10, 4, param_table_pkg::OP_WRITE_ENABLE, 1'b0, 24'h0, 0, 1'b1);
        check(write_enable_latch_flag, 1'b1);
        do_reset();
        @(posedge sys_clk_i);
        #1;
        check(write_enable_latch_flag, 1'b0);
        check(dpd, 1'b0);
        wait_ready(n);
        // Whole table in every valid line mode, straight after power-up
        for (int m = 0; m < 3; m++) begin
            cmd(2'(m), 1 << m, param_table_pkg::OP_READ_PARAM_TABLE, 1'b1, 24'h000060,
                16, 1'b0);
            check(word(0), exp_w[0]);
            check(word(1), exp_w[1]);
            check(word(2), exp_w[2]);
            check(word(3), exp_w[3]);
        end
        // Start one byte below the table, then run off its top
        cmd(2'b00, 1, param_table_pkg::OP_READ_PARAM_TABLE, 1'b1, 24'h00005F, 4, 1'b0);
        check(word(0), 32'h003600FF);
        cmd(2'b01, 2, param_table_pkg::OP_READ_PARAM_TABLE, 1'b1, 24'h00006E, 4, 1'b0);
        check(word(0), 32'hFFFFFFFF);
        // Invalid line mode: no output at all
        cmd(2'b11, 1, param_table_pkg::OP_READ_PARAM_TABLE, 1'b1, 24'h000060, 2, 1'b1);
        cmd(2'b00, 1, param_table_pkg::OP_WRITE_ENABLE, 1'b0, 24'h0, 0, 1'b1);
        check(write_enable_latch_flag, 1'b1);
        cmd(2'b00, 1, param_table_pkg::OP_WRITE_DISABLE, 1'b0, 24'h0, 0, 1'b1);
        check(write_enable_latch_flag, 1'b0);
        // Power-down refuses reads and writes until released
        cmd(2'b00, 1, param_table_pkg::OP_DEEP_POWER_DOWN, 1'b0, 24'h0, 0, 1'b1);
        check(dpd, 1'b1);
        cmd(2'b00, 1, param_table_pkg::OP_READ_PARAM_TABLE, 1'b1, 24'h000060, 2, 1'b1);
        cmd(2'b00, 1, param_table_pkg::OP_WRITE_ENABLE, 1'b0, 24'h0, 0, 1'b1);
        check(write_enable_latch_flag, 1'b0);
        cmd(2'b00, 1, param_table_pkg::OP_RELEASE_POWER_DOWN, 1'b0, 24'h0, 0, 1'b1);
        check(dpd, 1'b0);
        cmd(2'b10, 4, param_table_pkg::OP_READ_PARAM_TABLE, 1'b1, 24'h000060, 4, 1'b0);
        check(word(0), exp_w[0]);
        final_report();
    end
endmodule
